// File: sbpb_defines.vh
`ifndef SBPB_DEFINES_VH
`define SBPB_DEFINES_VH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define SBPB_IDX_NODE_STATUS 4'h0
`define SBPB_IDX_RESET_GAP 4'h1
`define SBPB_IDX_EXT_PORTS 4'h2
`define SBPB_IDX_SPEED_DELAY 4'h3
`define SBPB_IDX_LINK_POWER 4'h4
`define SBPB_IDX_EVENT_ARB 4'h5
`define SBPB_IDX_RSVD_SIX 4'h6
`define SBPB_IDX_PAGE_PORT 4'h7
`define SBPB_PAGED_BIT 3

// ----------------------------------------------------------------
// Field positions (bit 7 is the first bit on the wire)
// ----------------------------------------------------------------
`define SBPB_R1_HOLDOFF 7
`define SBPB_R1_LONG_RST 6
`define SBPB_R4_LINK_ACTIVE_CONTROL 7
`define SBPB_R4_CONTEND 6
`define SBPB_R5_WATCHDOG 7
`define SBPB_R5_SHORT_RST 6
`define SBPB_R5_LOOP 5
`define SBPB_R5_PWR_FAIL 4
`define SBPB_R5_TIMEOUT 3
`define SBPB_R5_PORT_EVT 2
`define SBPB_R5_ACCEL 1
`define SBPB_R5_MULTI 0

// ----------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------
`define SBPB_EXTENDED 3'h7
`define SBPB_TOTAL_PORTS 4'h2
`define SBPB_MAX_SPEED 3'h2
`define SBPB_DELAY 4'h0
`define SBPB_JITTER 3'h0
`define SBPB_GAP_RESET 6'h3f
`define SBPB_LINK_ACTIVE_CONTROL_RESET 1'b1
`define SBPB_PAGE_RSVD_LO 3'h2
`define SBPB_PAGE_RSVD_HI 3'h6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SBPB_CLK_PERIOD_NS 10
`define SBPB_LONG_RESET_NS 166000
`define SBPB_SHORT_RESET_NS 1300
// Cycle counts of both reset lengths at the 10 ns clock, sized for the 15-bit counter
`define SBPB_LONG_RESET_CYC 15'h40d8
`define SBPB_SHORT_RESET_CYC 15'h0082

`endif

// File: sbpb_sync.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-flop synchroniser for a bundle of pin levels
// ----------------------------------------------------------------
module sbpb_sync
#(
    parameter W = 5
)
(
    input wire clk,
    input wire nrst,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;

always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        meta_r <= {W{1'b0}};
        sync_r <= {W{1'b0}};
    end
    else
    begin
        meta_r <= d;
        sync_r <= meta_r;
    end
end

assign q = sync_r;

endmodule

// File: sbpb_reset_gen.v
`timescale 1ns/1ps
`include "sbpb_defines.vh"
// ----------------------------------------------------------------
// Bus reset generator: waits for an idle bus, then drives a timed reset
// ----------------------------------------------------------------
module sbpb_reset_gen
#(
    parameter [14:0] LONG_CYC = `SBPB_LONG_RESET_CYC
)
(
    input wire clk,
    input wire nrst,
    input wire long_req,
    input wire short_req,
    input wire bus_busy,
    output wire start,
    output reg active_r,
    output reg is_long_r
);

localparam [14:0] SHORT_CYC = `SBPB_SHORT_RESET_CYC;

reg [14:0] cnt_r;

// Start only between packets so a transfer in flight is never cut
assign start = !active_r && !bus_busy && (long_req || short_req);

always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        active_r <= 1'b0;
        is_long_r <= 1'b0;
        cnt_r <= 15'h0000;
    end
    else if (start)
    begin
        active_r <= 1'b1;
        // Long wins when both are asked for
        is_long_r <= long_req;
        cnt_r <= long_req ? LONG_CYC - 15'h0001 : SHORT_CYC - 15'h0001;
    end
    else if (active_r)
    begin
        if (cnt_r == 15'h0000)
            active_r <= 1'b0;
        else
            cnt_r <= cnt_r - 15'h0001;
    end
end

endmodule

// File: sbpb_base_regs.v
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "sbpb_defines.vh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module sbpb_base_regs
#(
    parameter [14:0] LONG_RESET_CYC = `SBPB_LONG_RESET_CYC
)
(
    input wire clk,
    input wire nrst,
    // Avalon-MM slave
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Pins
    input wire cable_power_ok,
    input wire link_power_status_in,
    input wire [2:0] power_class_pins,
    // Events from the arbitration core
    input wire bus_reset_in,
    input wire self_id_done_in,
    input wire [5:0] self_id_addr_in,
    input wire tree_id_root_in,
    input wire phy_config_gap_in,
    input wire [5:0] phy_config_gap_val_in,
    input wire loop_detect_in,
    input wire state_timeout_in,
    input wire port_change_in,
    input wire resume_start_in,
    input wire bus_busy_in,
    // Controls to the core and the link interface
    output wire [5:0] node_address,
    output reg node_address_valid_r,
    output reg status_xfer_req_r,
    output wire [7:0] status_xfer_data,
    output wire root_holdoff,
    output wire [5:0] gap_count,
    output wire enab_accel,
    output wire enab_multi,
    output wire selfid_link_active,
    output wire selfid_contender,
    output wire [2:0] selfid_power_class,
    output wire link_if_enable,
    output wire bus_reset_drive,
    output wire bus_reset_long
);

// ----------------------------------------------------------------
// Register state
// ----------------------------------------------------------------
reg [5:0] node_addr_r;
reg root_r;
reg holdoff_r;
reg long_req_r;
reg [5:0] gap_r;
reg gap_stale_r;
reg link_active_control_r;
reg contend_r;
reg [2:0] pwr_class_r;
reg [1:0] pwr_load_cnt_r;
reg watchdog_r;
reg short_req_r;
reg loop_r;
reg pwr_fail_r;
reg timeout_r;
reg port_evt_r;
reg accel_r;
reg multi_r;
reg [2:0] page_r;
reg [3:0] port_sel_r;
reg ack_r;
reg cps_prev_r;

wire [4:0] pins_sync;
wire cps_s;
wire lps_s;
wire [2:0] pc_s;
wire rst_start;
wire rst_active;
wire rst_long;
wire bus_reset;
wire [3:0] idx;
wire wr;
wire [7:0] wd;
wire pwr_fail_set;
wire port_evt_set;
wire gap_update;

// ----------------------------------------------------------------
// Decode helpers
// ----------------------------------------------------------------
function is_write_lane;
    input do_write;
    input [3:0] lanes;
    begin
        is_write_lane = do_write && lanes[0];
    end
endfunction

function [7:0] paged_read;
    input [2:0] page;
    input [2:0] sub;
    begin
        // Pages two to six are reserved; other page contents are not built here
        if (page >= `SBPB_PAGE_RSVD_LO && page <= `SBPB_PAGE_RSVD_HI)
            paged_read = 8'h00;
        else
            paged_read = 8'h00 | {5'h00, sub & 3'h0};
    end
endfunction

// ----------------------------------------------------------------
// Pin synchronisers and reset generator
// ----------------------------------------------------------------
sbpb_sync #(.W(5)) u_sync
(
    .clk(clk),
    .nrst(nrst),
    .d({cable_power_ok, link_power_status_in, power_class_pins}),
    .q(pins_sync)
);

assign cps_s = pins_sync[4];
assign lps_s = pins_sync[3];
assign pc_s = pins_sync[2:0];

sbpb_reset_gen #(.LONG_CYC(LONG_RESET_CYC)) u_rst
(
    .clk(clk),
    .nrst(nrst),
    .long_req(long_req_r),
    .short_req(short_req_r),
    .bus_busy(bus_busy_in),
    .start(rst_start),
    .active_r(rst_active),
    .is_long_r(rst_long)
);

// A reset we start ourselves counts as a bus reset too
assign bus_reset = bus_reset_in || rst_start;

// ----------------------------------------------------------------
// Avalon-MM slave: one wait cycle, answer on the second edge
// ----------------------------------------------------------------
assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
assign idx = avs_address[5:2];
// Write lands at the edge that shows waitrequest low, where the master commits it
assign wr = is_write_lane(avs_write && ack_r, avs_byteenable);
assign wd = avs_writedata[7:0];

always @(posedge clk or negedge nrst)
begin
    if (!nrst)
        ack_r <= 1'b0;
    else
        ack_r <= (avs_read || avs_write) && !ack_r;
end

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
        avs_readdata <= 32'h00000000;
    else if (avs_read && !ack_r)
    begin
        avs_readdata[31:8] <= 24'h000000;
        if (idx[`SBPB_PAGED_BIT])
            avs_readdata[7:0] <= paged_read(page_r, idx[2:0]);
        else
        begin
            case (idx)
                `SBPB_IDX_NODE_STATUS:
                    avs_readdata[7:0] <= {node_addr_r, root_r, cps_s};
                `SBPB_IDX_RESET_GAP:
                    avs_readdata[7:0] <= {holdoff_r, long_req_r, gap_r};
                `SBPB_IDX_EXT_PORTS:
                    avs_readdata[7:0] <= {`SBPB_EXTENDED, 1'b0, `SBPB_TOTAL_PORTS};
                `SBPB_IDX_SPEED_DELAY:
                    avs_readdata[7:0] <= {`SBPB_MAX_SPEED, 1'b0, `SBPB_DELAY};
                `SBPB_IDX_LINK_POWER:
                    avs_readdata[7:0] <= {link_active_control_r, contend_r, `SBPB_JITTER, pwr_class_r};
                `SBPB_IDX_EVENT_ARB:
                    avs_readdata[7:0] <= {watchdog_r, short_req_r, loop_r, pwr_fail_r,
                                          timeout_r, port_evt_r, accel_r, multi_r};
                `SBPB_IDX_PAGE_PORT:
                    avs_readdata[7:0] <= {page_r, 1'b0, port_sel_r};
                default:
                    avs_readdata[7:0] <= 8'h00;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Identity and root
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        node_addr_r <= 6'h00;
        node_address_valid_r <= 1'b0;
        status_xfer_req_r <= 1'b0;
        root_r <= 1'b0;
    end
    else
    begin
        status_xfer_req_r <= 1'b0;
        if (bus_reset)
        begin
            node_address_valid_r <= 1'b0;
            root_r <= 1'b0;
        end
        else
        begin
            if (tree_id_root_in)
                root_r <= 1'b1;
            if (self_id_done_in)
            begin
                node_addr_r <= self_id_addr_in;
                node_address_valid_r <= 1'b1;
                status_xfer_req_r <= 1'b1;
            end
        end
    end
end

// Unsolicited register-0 image, valid with the request pulse
assign status_xfer_data = {node_addr_r, root_r, cps_s};

// ----------------------------------------------------------------
// Register 1: holdoff, long reset, gap count
// ----------------------------------------------------------------
assign gap_update = (wr && idx == `SBPB_IDX_RESET_GAP) || phy_config_gap_in;

always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        holdoff_r <= 1'b0;
        long_req_r <= 1'b0;
        gap_r <= `SBPB_GAP_RESET;
        gap_stale_r <= 1'b0;
    end
    else
    begin
        if (wr && idx == `SBPB_IDX_RESET_GAP)
        begin
            holdoff_r <= wd[`SBPB_R1_HOLDOFF];
            long_req_r <= wd[`SBPB_R1_LONG_RST];
            gap_r <= wd[5:0];
        end
        else if (phy_config_gap_in)
            gap_r <= phy_config_gap_val_in;
        // A bus reset consumes the request even if written in the same cycle
        if (bus_reset)
            long_req_r <= 1'b0;
        if (gap_update)
            gap_stale_r <= 1'b0;
        else if (bus_reset)
        begin
            gap_stale_r <= 1'b1;
            if (gap_stale_r)
                gap_r <= `SBPB_GAP_RESET;
        end
    end
end

// ----------------------------------------------------------------
// Register 4: link control, contender, power class
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        link_active_control_r <= `SBPB_LINK_ACTIVE_CONTROL_RESET;
        contend_r <= 1'b0;
        pwr_class_r <= 3'h0;
        pwr_load_cnt_r <= 2'h0;
    end
    else
    begin
        // Pins take two edges to settle through the synchroniser
        if (pwr_load_cnt_r != 2'h3)
            pwr_load_cnt_r <= pwr_load_cnt_r + 2'h1;
        if (pwr_load_cnt_r == 2'h2)
            pwr_class_r <= pc_s;
        if (wr && idx == `SBPB_IDX_LINK_POWER)
        begin
            link_active_control_r <= wd[`SBPB_R4_LINK_ACTIVE_CONTROL];
            contend_r <= wd[`SBPB_R4_CONTEND];
            pwr_class_r <= wd[2:0];
        end
    end
end

// ----------------------------------------------------------------
// Register 5: enables and sticky events
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
        cps_prev_r <= 1'b0;
    else
        cps_prev_r <= cps_s;
end

assign pwr_fail_set = cps_prev_r && !cps_s;
assign port_evt_set = port_change_in || (watchdog_r && resume_start_in);

always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        watchdog_r <= 1'b0;
        short_req_r <= 1'b0;
        loop_r <= 1'b0;
        pwr_fail_r <= 1'b0;
        timeout_r <= 1'b0;
        port_evt_r <= 1'b0;
        accel_r <= 1'b0;
        multi_r <= 1'b0;
    end
    else
    begin
        if (wr && idx == `SBPB_IDX_EVENT_ARB)
        begin
            watchdog_r <= wd[`SBPB_R5_WATCHDOG];
            short_req_r <= wd[`SBPB_R5_SHORT_RST];
            accel_r <= wd[`SBPB_R5_ACCEL];
            multi_r <= wd[`SBPB_R5_MULTI];
            if (wd[`SBPB_R5_LOOP])
                loop_r <= 1'b0;
            if (wd[`SBPB_R5_PWR_FAIL])
                pwr_fail_r <= 1'b0;
            if (wd[`SBPB_R5_TIMEOUT])
                timeout_r <= 1'b0;
            if (wd[`SBPB_R5_PORT_EVT])
                port_evt_r <= 1'b0;
        end
        if (bus_reset)
            short_req_r <= 1'b0;
        // Sets come last so an event in the clearing cycle is kept
        if (loop_detect_in)
            loop_r <= 1'b1;
        if (pwr_fail_set)
            pwr_fail_r <= 1'b1;
        if (state_timeout_in)
            timeout_r <= 1'b1;
        if (port_evt_set)
            port_evt_r <= 1'b1;
    end
end

// ----------------------------------------------------------------
// Register 7: page and port selectors
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        page_r <= 3'h0;
        port_sel_r <= 4'h0;
    end
    else if (wr && idx == `SBPB_IDX_PAGE_PORT)
    begin
        page_r <= wd[7:5];
        port_sel_r <= wd[3:0];
    end
end

// ----------------------------------------------------------------
// Outputs to the core
// ----------------------------------------------------------------
assign node_address = node_addr_r;
assign root_holdoff = holdoff_r;
assign gap_count = gap_r;
assign enab_accel = accel_r;
assign enab_multi = multi_r;
assign selfid_link_active = link_active_control_r && lps_s;
assign selfid_contender = contend_r;
assign selfid_power_class = pwr_class_r;
// The control bit only shapes self-ID, never the interface itself
assign link_if_enable = lps_s;
assign bus_reset_drive = rst_active;
assign bus_reset_long = rst_long;

endmodule

// File: sbpb_chk.sv
`timescale 1ns/1ps
`include "sbpb_defines.vh"
// ----------------------------------------------------------------
// Port-level checker for the base register bank
// ----------------------------------------------------------------
module sbpb_chk
#(
    parameter [14:0] LONG_RESET_CYC = 15'd20
)
(
    input wire clk,
    input wire nrst,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire cable_power_ok,
    input wire link_power_status_in,
    input wire bus_reset_in,
    input wire self_id_done_in,
    input wire [5:0] self_id_addr_in,
    input wire tree_id_root_in,
    input wire phy_config_gap_in,
    input wire [5:0] phy_config_gap_val_in,
    input wire bus_busy_in,
    input wire [5:0] node_address,
    input wire node_address_valid_r,
    input wire status_xfer_req_r,
    input wire [7:0] status_xfer_data,
    input wire [5:0] gap_count,
    input wire selfid_link_active,
    input wire link_if_enable,
    input wire bus_reset_drive,
    input wire bus_reset_long
);
    localparam [15:0] SHORT_CYC = `SBPB_SHORT_RESET_CYC;
    // Counts high cycles of the generated reset; too long to unroll as a repetition
    logic [15:0] hi_cnt_r;
    always @(posedge clk or negedge nrst)
        if (!nrst)
            hi_cnt_r <= 16'h0;
        else
            hi_cnt_r <= bus_reset_drive ? hi_cnt_r + 16'h1 : 16'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    upper_lanes_a: assert property (avs_readdata[31:8] == 24'h0)
        else $error("readdata upper lanes not zero");
    one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("waitrequest held too long");
    status_xfer_a: assert property (self_id_done_in |=> status_xfer_req_r &&
        node_address == $past(self_id_addr_in)) else $error("self-id status missing");
    status_addr_a: assert property (status_xfer_req_r |->
        status_xfer_data[7:2] == $past(self_id_addr_in))
        else $error("status data address differs");
    addr_invalid_a: assert property (bus_reset_in |=> !node_address_valid_r)
        else $error("address still valid after bus reset");
    root_clear_a: assert property (bus_reset_in |=> !status_xfer_data[1])
        else $error("root not cleared by bus reset");
    root_set_a: assert property (tree_id_root_in && !bus_reset_in |=> status_xfer_data[1])
        else $error("root not set");
    cps_mirror_a: assert property ($stable(cable_power_ok) [*4] |->
        status_xfer_data[0] == cable_power_ok) else $error("cable power bit wrong");
    lps_follow_a: assert property ($stable(link_power_status_in) [*4] |->
        link_if_enable == link_power_status_in) else $error("link interface enable wrong");
    link_and_a: assert property (selfid_link_active |-> link_if_enable)
        else $error("self-id link bit without link power");
    gap_cfg_a: assert property (phy_config_gap_in && !bus_reset_in |=>
        gap_count == $past(phy_config_gap_val_in)) else $error("gap not loaded by config");
    start_idle_a: assert property ($rose(bus_reset_drive) |-> !$past(bus_busy_in))
        else $error("reset started during traffic");
    reset_len_a: assert property ($fell(bus_reset_drive) |-> hi_cnt_r ==
        (bus_reset_long ? {1'b0, LONG_RESET_CYC} : SHORT_CYC)) else $error("reset length wrong");
endmodule
bind sbpb_base_regs sbpb_chk #(.LONG_RESET_CYC(LONG_RESET_CYC)) i_chk (.clk, .nrst,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .cable_power_ok,
    .link_power_status_in, .bus_reset_in, .self_id_done_in, .self_id_addr_in,
    .tree_id_root_in, .phy_config_gap_in, .phy_config_gap_val_in, .bus_busy_in,
    .node_address, .node_address_valid_r, .status_xfer_req_r, .status_xfer_data,
    .gap_count, .selfid_link_active, .link_if_enable, .bus_reset_drive, .bus_reset_long);

// File: sbpb_llc.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link controller model: Avalon-MM master
// ----------------------------------------------------------------
module sbpb_llc
(
    input wire clk,
    output logic [5:0] avs_address = 6'h3f,
    output logic avs_read = 1'b0,
    output logic avs_write = 1'b0,
    output logic [31:0] avs_writedata = 32'h0,
    output logic [3:0] avs_byteenable = 4'h0,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest
);
    // Request held until waitrequest is seen low; no fixed latency assumed
    task automatic xfer(input w, input [3:0] i, input [7:0] d, input [3:0] be,
        output [7:0] q);
        @(posedge clk);
        avs_address <= {i, 2'h0};
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Released lines change, so a stale value is never mistaken for data
        avs_address <= ~avs_address;
        avs_writedata <= ~avs_writedata;
    endtask
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
// ----------------------------------------------------------------
// Register bank testbench
// ----------------------------------------------------------------
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, cable_power_ok = 1'b1;
    logic link_power_status_in = 1'b1, bus_busy_in = 1'b0;
    logic [5:0] ev = 6'h0, self_id_addr_in = 6'h0, phy_config_gap_val_in = 6'h0;
    logic [7:0] q;
    logic [7:0] rv [8] = '{8'h01, 8'h3f, 8'he2, 8'h40, 8'h85, 8'h00, 8'h00, 8'h00};
    logic [3:0] ro [4] = '{4'h0, 4'h2, 4'h3, 4'h6};
    int failures = 0;
    int check_count = 0;
    wire [5:0] avs_address, node_address, gap_count;
    wire [31:0] avs_writedata, avs_readdata;
    wire [3:0] avs_byteenable;
    wire [2:0] selfid_power_class;
    wire avs_read, avs_write, avs_waitrequest, node_address_valid_r, root_holdoff;
    wire selfid_link_active, selfid_contender, link_if_enable, bus_reset_drive, bus_reset_long;
    wire enab_accel, enab_multi;
    always #5 clk = ~clk;
    sbpb_llc i_llc (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest);
    // Short long-reset count keeps the run brief; the checker derives from it
    sbpb_base_regs #(.LONG_RESET_CYC(15'd20)) i_dut (.clk, .nrst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .cable_power_ok, .link_power_status_in,
        .power_class_pins(3'h5), .bus_reset_in(ev[0]), .self_id_done_in(ev[1]),
        .self_id_addr_in, .tree_id_root_in(ev[2]), .phy_config_gap_in(ev[3]),
        .phy_config_gap_val_in, .loop_detect_in(ev[4]), .state_timeout_in(1'b0),
        .port_change_in(1'b0), .resume_start_in(ev[5]), .bus_busy_in, .node_address,
        .node_address_valid_r, .status_xfer_req_r(), .status_xfer_data(), .root_holdoff,
        .gap_count, .enab_accel, .enab_multi, .selfid_link_active, .selfid_contender,
        .selfid_power_class, .link_if_enable, .bus_reset_drive, .bus_reset_long);
    task automatic wr(input [3:0] i, input [7:0] d);
        i_llc.xfer(1'b1, i, d, 4'h1, q);
    endtask
    task automatic rc(input [3:0] i, input [7:0] m, input [7:0] e);
        i_llc.xfer(1'b0, i, 8'h00, 4'h0, q);
        `CK($sformatf("reg%0d", i), e, q & m)
    endtask
    task automatic pulse(input [5:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 6'h0;
    endtask
    task give_verdict;
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        // Pin levels need the synchroniser edges before register 0 shows them
        repeat (3) @(posedge clk);
        for (int k = 0; k < 8; k++)
            rc(k[3:0], 8'hff, rv[k]);
        foreach (ro[k])
            wr(ro[k], 8'hff);
        i_llc.xfer(1'b1, 4'h1, 8'h00, 4'h0, q);
        for (int k = 0; k < 8; k++)
            rc(k[3:0], 8'hff, rv[k]);
        for (int p = 0; p < 8; p++)
        begin
            wr(4'h7, {p[2:0], 5'h19});
            rc(4'h7, 8'hff, {p[2:0], 5'h09});
            rc(4'h8, 8'hff, 8'h00);
            rc(4'hf, 8'hff, 8'h00);
            rc(4'h2, 8'hff, 8'he2);
        end
        wr(4'h4, 8'h7a);
        rc(4'h4, 8'hff, 8'h42);
        `CK("contender", 1'b1, selfid_contender)
        `CK("pwr_class", 3'h2, selfid_power_class)
        `CK("link_bit", 1'b0, selfid_link_active)
        `CK("link_if", 1'b1, link_if_enable)
        wr(4'h4, 8'hc2);
        rc(4'h4, 8'hff, 8'hc2);
        `CK("link_bit", 1'b1, selfid_link_active)
        link_power_status_in <= 1'b0;
        repeat (4) @(posedge clk);
        `CK("link_bit", 1'b0, selfid_link_active)
        `CK("link_if", 1'b0, link_if_enable)
        link_power_status_in <= 1'b1;
        wr(4'h1, 8'h85);
        pulse(6'h01);
        rc(4'h1, 8'hff, 8'h85);
        `CK("holdoff", 1'b1, root_holdoff)
        pulse(6'h01);
        rc(4'h1, 8'hff, 8'hbf);
        rc(4'h4, 8'hff, 8'hc2);
        rc(4'h7, 8'hff, 8'he9);
        phy_config_gap_val_in <= 6'h11;
        pulse(6'h08);
        rc(4'h1, 8'h3f, 8'h11);
        pulse(6'h01);
        rc(4'h1, 8'h3f, 8'h11);
        self_id_addr_in <= 6'h2d;
        pulse(6'h06);
        rc(4'h0, 8'hff, 8'hb7);
        `CK("addr_valid", 1'b1, node_address_valid_r)
        pulse(6'h01);
        rc(4'h0, 8'h02, 8'h00);
        `CK("addr_valid", 1'b0, node_address_valid_r)
        cable_power_ok <= 1'b0;
        repeat (4) @(posedge clk);
        rc(4'h0, 8'h01, 8'h00);
        rc(4'h5, 8'h10, 8'h10);
        cable_power_ok <= 1'b1;
        wr(4'h5, 8'h10);
        rc(4'h5, 8'hff, 8'h00);
        pulse(6'h20);
        rc(4'h5, 8'hff, 8'h00);
        wr(4'h5, 8'h80);
        pulse(6'h30);
        rc(4'h5, 8'hff, 8'ha4);
        wr(4'h5, 8'ha4);
        rc(4'h5, 8'hff, 8'h80);
        wr(4'h5, 8'h83);
        rc(4'h5, 8'hff, 8'h83);
        `CK("accel_multi", 2'h3, {enab_accel, enab_multi})
        bus_busy_in <= 1'b1;
        wr(4'h1, 8'h51);
        repeat (10) @(posedge clk);
        `CK("reset_drive", 1'b0, bus_reset_drive)
        bus_busy_in <= 1'b0;
        while (bus_reset_drive !== 1'b1)
            @(posedge clk);
        `CK("reset_long", 1'b1, bus_reset_long)
        while (bus_reset_drive !== 1'b0)
            @(posedge clk);
        rc(4'h1, 8'h40, 8'h00);
        wr(4'h5, 8'h40);
        while (bus_reset_drive !== 1'b1)
            @(posedge clk);
        `CK("reset_long", 1'b0, bus_reset_long)
        while (bus_reset_drive !== 1'b0)
            @(posedge clk);
        rc(4'h5, 8'h40, 8'h00);
        give_verdict();
    end
    initial
    begin
        #200000;
        failures++;
        give_verdict();
    end
endmodule
